// [hdl/psu_cfg.svh]
// Offsets, field positions, reset values and threshold tables for the phase/lockout config bank
`ifndef PSU_CFG_SVH
`define PSU_CFG_SVH
`define PSU_CMD_SHED_THRESH   8'hDF
`define PSU_CMD_INPUT_LOCKOUT 8'hE0
`define PSU_CMD_MAX_PHASE     8'hE4
`define PSU_CMD_UV_OFFSET     8'hE6
`define PSU_CMD_PART_ID       8'hFC
`define PSU_RST_SHED_THRESH   8'h01
`define PSU_RST_INPUT_LOCKOUT 8'h01
`define PSU_RST_UV_OFFSET     8'h03
`define PSU_SINGLE_BIT        3
`define PSU_STATUS_PHASE_BIT  3
`define PSU_SINGLE_PCT        7'h0A
`define PSU_DUAL_PCT_0        7'h0F
`define PSU_DUAL_PCT_1        7'h14
`define PSU_DUAL_PCT_2        7'h19
`define PSU_DUAL_PCT_3        7'h1E
`define PSU_DUAL_PCT_HI       7'h23
`define PSU_LOCK_MV_0         14'h1194
`define PSU_LOCK_MV_1         14'h1C52
`define PSU_LOCK_MV_2         14'h2328
`define PSU_LOCK_MV_3         14'h283C
`define PSU_UV_MV_LIST        {9'h190, 9'h145, 9'h12C, 9'h0FA, 9'h0C8, 9'h096, 9'h064, 9'h032}
`endif

// [hdl/psu_pkg.sv]
// Types shared by the phase/lockout config bank
package psu_pkg;
   typedef enum logic [1:0] {
      PSU_PH_ONE  = 2'h0,
      PSU_PH_TWO  = 2'h1,
      PSU_PH_FULL = 2'h3
   } psu_shed_type;
endpackage

// [hdl/psu_trip_calc.sv]
// Output undervoltage trip level arithmetic
`timescale 1ns/1ps
`include "psu_cfg.svh"
module psu_trip_calc (
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        resetn,
   // Operands
   input  wire logic [15:0] vout_cmd_mv,
   input  wire logic [15:0] load_line_uohm,
   input  wire logic [15:0] iout_a,
   input  wire logic [2:0]  offset_sel,
   // Result
   output logic      [15:0] trip_mv
);
   localparam logic [71:0] UV_TABLE = `PSU_UV_MV_LIST;

   typedef struct packed {
      logic [15:0] trip;
   } psu_trip_state_type;

   psu_trip_state_type st_q;
   psu_trip_state_type st_d;
   logic [31:0]        drop_full;
   logic [22:0]        drop_mv;
   logic [8:0]         margin_mv;
   logic [24:0]        diff;

   always_comb begin
      // uohm * A = uV; divide by 1000 for mV
      drop_full = load_line_uohm * iout_a;
      // Drop kept wide so a large product clamps instead of wrapping
      drop_mv   = 23'(drop_full / 32'd1000);
      margin_mv = UV_TABLE[offset_sel*9 +: 9];
      diff      = {9'h000, vout_cmd_mv} - {2'h0, drop_mv} - {16'h0000, margin_mv};
      st_d      = st_q;
      st_d.trip = diff[24] ? 16'h0000 : diff[15:0];
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign trip_mv = st_q.trip;
endmodule

// [hdl/psu_cfg_regs.sv]
// Manufacturer config bank: shedding thresholds, input lockout, phase count, UV offset, identity
//
// How it works
// - Bit 3 of the shedding register allows the two-to-one phase drop at 10% load, or forbids one phase if 0.
// - Bits 2:0 set the four-to-two drop at 15, 20, 25, 30 percent, and 35 percent for any other code.
// - Load percent is measured against four times the per-phase current limit.
// - The two-bit lockout field picks 4.5, 7.25, 9.0 or 10.3 V and resets to 01.
// - A new maximum phase count is taken while running, with no restart.
// - The phase count field holds the count minus one, up to HW_PHASES_M1 + 1 phases (four by default).
// - A count above the hardware phases is refused, status bit 3 is set and the alert asserts.
// - UV trip equals commanded voltage minus load-line drop minus the offset.
// - The three-bit offset picks 50,100,150,200,250,300,325 or 400 mV.
// - The identity command returns a fixed read-only 16-bit code.
// - Shedding only happens while the shedding enable is 1.
`timescale 1ns/1ps
`include "psu_cfg.svh"
module psu_cfg_regs #(
   parameter logic [2:0]  HW_PHASES_M1 = 3'h3,
   parameter logic [15:0] PART_ID      = 16'h5A5A // Arbitrary value
) (
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        resetn,
   // Command port from the bus framer
   input  wire logic        cmd_wr,
   input  wire logic        cmd_rd,
   input  wire logic [7:0]  cmd_code,
   input  wire logic [15:0] cmd_wdata,
   output logic      [15:0] cmd_rdata,
   output logic             cmd_rvalid,
   output logic             cmd_unmapped,
   // Status clear from the status command
   input  wire logic        status_clear,
   output logic      [7:0]  mfr_status,
   output logic             host_alert_output,
   // Regulator inputs
   input  wire logic        shedding_enable,
   input  wire logic [15:0] per_phase_current_limit,
   input  wire logic [15:0] load_current,
   input  wire logic [15:0] vout_cmd_mv,
   input  wire logic [15:0] load_line_uohm,
   input  wire logic [15:0] iout_a,
   // Outputs to the power stage control
   output logic      [2:0]  max_phase_m1,
   output logic      [1:0]  shed_phase_mode,
   output logic      [13:0] input_lockout_mv,
   output logic             input_undervoltage_lockout_sel_valid,
   output logic      [15:0] uv_trip_mv
);
   typedef struct packed {
      // Register fields
      logic                shed_to_single_threshold;
      logic [2:0]          shed_to_dual_threshold;
      logic [1:0]          input_lockout_select;
      logic [2:0]          phase_m1;
      logic [2:0]          undervoltage_margin_select;
      // Sticky status
      logic                phase_err;
      logic                alert;
      // Read port
      logic [15:0]         rdata;
      logic                rvalid;
      logic                unmapped;
      // Derived controls
      psu_pkg::psu_shed_type shed;
      logic [13:0]         lock_mv;
      logic                lock_valid;
      // Enable pin synchroniser
      logic                en_meta;
      logic                en_sync;
   } psu_state_type;

   psu_state_type st_q;
   psu_state_type st_d;
   logic [17:0]   full_load;
   logic [24:0]   load_x100;
   logic [6:0]    dual_pct;
   logic [24:0]   dual_lim;
   logic [24:0]   single_lim;
   logic          below_single;
   logic          below_dual;
   logic          phase_over;
   logic [15:0]   rd_word;
   logic          rd_known;

   psu_trip_calc u_trip (
      .ref_clk        (ref_clk),
      .resetn         (resetn),
      .vout_cmd_mv    (vout_cmd_mv),
      .load_line_uohm (load_line_uohm),
      .iout_a         (iout_a),
      .offset_sel     (st_q.undervoltage_margin_select),
      .trip_mv        (uv_trip_mv)
   );

   // Readback word; reserved positions stay zero
   always_comb begin
      rd_word  = 16'h0000;
      rd_known = 1'b1;
      unique case (cmd_code)
         `PSU_CMD_SHED_THRESH: begin
            rd_word[`PSU_SINGLE_BIT] = st_q.shed_to_single_threshold;
            rd_word[2:0]             = st_q.shed_to_dual_threshold;
         end
         `PSU_CMD_INPUT_LOCKOUT: rd_word[1:0] = st_q.input_lockout_select;
         `PSU_CMD_MAX_PHASE:     rd_word[2:0] = st_q.phase_m1;
         `PSU_CMD_UV_OFFSET:     rd_word[2:0] = st_q.undervoltage_margin_select;
         `PSU_CMD_PART_ID:       rd_word      = PART_ID;
         default:                rd_known     = 1'b0;
      endcase
   end

   always_comb begin
      st_d          = st_q;
      st_d.rvalid   = 1'b0;
      st_d.unmapped = 1'b0;
      full_load     = {per_phase_current_limit, 2'b00};
      load_x100     = 25'(load_current) * 25'd100;

      // Four-to-two threshold in percent
      unique case (st_q.shed_to_dual_threshold)
         3'h0: dual_pct = `PSU_DUAL_PCT_0;
         3'h1: dual_pct = `PSU_DUAL_PCT_1;
         3'h2: dual_pct = `PSU_DUAL_PCT_2;
         3'h3: dual_pct = `PSU_DUAL_PCT_3;
         default: dual_pct = `PSU_DUAL_PCT_HI;
      endcase
      dual_lim     = 25'(full_load) * 25'(dual_pct);
      single_lim   = 25'(full_load) * 25'(`PSU_SINGLE_PCT);
      below_single = load_x100 < single_lim;
      below_dual   = load_x100 < dual_lim;
      phase_over   = cmd_wdata[2:0] > HW_PHASES_M1;

      // Enable pin crosses in through two flops
      st_d.en_meta = shedding_enable;
      st_d.en_sync = st_q.en_meta;

      // Phase mode from load, only while enabled
      if (!st_q.en_sync) begin
         st_d.shed = psu_pkg::PSU_PH_FULL;
      end else if (st_q.shed_to_single_threshold && below_single) begin
         st_d.shed = psu_pkg::PSU_PH_ONE;
      end else if (below_dual) begin
         st_d.shed = psu_pkg::PSU_PH_TWO;
      end else begin
         st_d.shed = psu_pkg::PSU_PH_FULL;
      end

      // Lockout level follows the select one cycle later
      unique case (st_q.input_lockout_select)
         2'h0: st_d.lock_mv = `PSU_LOCK_MV_0;
         2'h1: st_d.lock_mv = `PSU_LOCK_MV_1;
         2'h2: st_d.lock_mv = `PSU_LOCK_MV_2;
         2'h3: st_d.lock_mv = `PSU_LOCK_MV_3;
      endcase
      st_d.lock_valid = 1'b1;

      // Clear first, so a refusal in the same cycle wins
      if (status_clear) begin
         st_d.phase_err = 1'b0;
         st_d.alert     = 1'b0;
      end

      // Commands; a write wins over a read in the same cycle
      if (cmd_wr) begin
         unique case (cmd_code)
            `PSU_CMD_SHED_THRESH: begin
               st_d.shed_to_single_threshold = cmd_wdata[`PSU_SINGLE_BIT];
               st_d.shed_to_dual_threshold   = cmd_wdata[2:0];
            end
            `PSU_CMD_INPUT_LOCKOUT: st_d.input_lockout_select = cmd_wdata[1:0];
            `PSU_CMD_MAX_PHASE: begin
               if (phase_over) begin
                  st_d.phase_err = 1'b1;
                  st_d.alert     = 1'b1;
               end else begin
                  st_d.phase_m1 = cmd_wdata[2:0];
               end
            end
            `PSU_CMD_UV_OFFSET: st_d.undervoltage_margin_select = cmd_wdata[2:0];
            `PSU_CMD_PART_ID: st_d.unmapped = 1'b0;
            default: st_d.unmapped = 1'b1;
         endcase
      end else if (cmd_rd) begin
         st_d.rvalid   = 1'b1;
         st_d.rdata    = rd_word;
         st_d.unmapped = !rd_known;
      end
   end

   // Documented register defaults, phase count field reset to 3 (four phases)
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         st_q                            <= '0;
         st_q.shed_to_single_threshold   <= 1'(`PSU_RST_SHED_THRESH >> `PSU_SINGLE_BIT);
         st_q.shed_to_dual_threshold     <= 3'(`PSU_RST_SHED_THRESH);
         st_q.input_lockout_select       <= 2'(`PSU_RST_INPUT_LOCKOUT);
         st_q.undervoltage_margin_select <= 3'(`PSU_RST_UV_OFFSET);
         st_q.phase_m1                   <= 3'h3;
         st_q.shed                       <= psu_pkg::PSU_PH_FULL;
         st_q.lock_mv                    <= `PSU_LOCK_MV_1;
      end else begin
         st_q <= st_d;
      end
   end

   // Every output is a state bit
   assign cmd_rdata         = st_q.rdata;
   assign cmd_rvalid        = st_q.rvalid;
   assign cmd_unmapped      = st_q.unmapped;
   assign mfr_status        = {4'h0, st_q.phase_err, 3'h0};
   assign host_alert_output = st_q.alert;
   assign max_phase_m1      = st_q.phase_m1;
   assign shed_phase_mode   = st_q.shed;
   assign input_lockout_mv  = st_q.lock_mv;
   assign input_undervoltage_lockout_sel_valid = st_q.lock_valid;
endmodule

// [tb/psu_cfg_regs_checker.sv]
// Port assertions for the config bank
`timescale 1ns/1ps
module psu_cfg_regs_checker #(
   parameter logic [2:0]  HW_PHASES_M1 = 3'h3,
   parameter logic [15:0] PART_ID      = 16'h5A5A // Arbitrary value
) (
   // Clock, reset and commands
   input wire logic        ref_clk,
   input wire logic        resetn,
   input wire logic        cmd_wr,
   input wire logic        cmd_rd,
   input wire logic [7:0]  cmd_code,
   input wire logic [15:0] cmd_wdata,
   input wire logic [15:0] cmd_rdata,
   input wire logic        cmd_rvalid,
   // Status and controls
   input wire logic        status_clear,
   input wire logic [7:0]  mfr_status,
   input wire logic        host_alert_output,
   input wire logic        shedding_enable,
   input wire logic [2:0]  max_phase_m1,
   input wire logic [1:0]  shed_phase_mode,
   input wire logic [13:0] input_lockout_mv
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   wire logic        rd1 = cmd_rd && !cmd_wr;
   wire logic        ph  = cmd_wr && cmd_code == 8'hE4;
   logic      [13:0] lk [4] = '{14'h1194, 14'h1C52, 14'h2328, 14'h283C};
   a_read_answer: assert property (rd1 |=> cmd_rvalid) else $error("no read answer");
   a_ident_read: assert property (rd1 && cmd_code == 8'hFC |=> cmd_rdata == PART_ID) else $error("bad id");
   a_reserved_zero: assert property (rd1 && cmd_code inside {8'hDF, 8'hE0, 8'hE4, 8'hE6}
      |=> cmd_rdata[15:4] == 12'h000) else $error("reserved bits set");
   a_phase_take: assert property (ph && cmd_wdata[2:0] <= HW_PHASES_M1
      |=> max_phase_m1 == $past(cmd_wdata[2:0])) else $error("phase not taken");
   a_phase_refuse: assert property (ph && cmd_wdata[2:0] > HW_PHASES_M1
      |=> $stable(max_phase_m1) && host_alert_output && mfr_status[3]) else $error("phase not refused");
   a_alert_sticky: assert property (host_alert_output && !status_clear |=> host_alert_output) else $error("alert");
   a_shed_off: assert property (!shedding_enable [*3]
      |=> shed_phase_mode == 2'h3) else $error("shed while off");
   a_lock_level: assert property (cmd_wr && cmd_code == 8'hE0
      |-> ##2 input_lockout_mv == lk[$past(cmd_wdata[1:0], 2)]) else $error("lockout level");
endmodule

// [tb/psu_host_model.sv]
// Bus host model issuing config commands
`timescale 1ns/1ps
module psu_host_model (
   // Clock
   input wire logic        ref_clk,
   // Command port
   output logic            cmd_wr = 1'h0,
   output logic            cmd_rd = 1'h0,
   output logic [7:0]      cmd_code = 8'h00,
   output logic [15:0]     cmd_wdata = 16'h0000,
   input wire logic [15:0] cmd_rdata,
   input wire logic        cmd_rvalid
);
   task automatic wr(input logic [7:0] c, input logic [15:0] d);
      @(posedge ref_clk);
      cmd_wr <= 1'h1;
      cmd_code <= c;
      cmd_wdata <= d;
      @(posedge ref_clk);
      cmd_wr <= 1'h0;
      cmd_code <= ~c;
      cmd_wdata <= ~d;
      #1;
   endtask
   task automatic rd(input logic [7:0] c, output logic [15:0] d);
      @(posedge ref_clk);
      cmd_rd <= 1'h1;
      cmd_code <= c;
      @(posedge ref_clk);
      cmd_rd <= 1'h0;
      cmd_code <= ~c;
      #1;
      d = cmd_rvalid ? cmd_rdata : 16'hDEAD;
   endtask
endmodule

// [tb/test_psu_cfg_regs.sv]
// Bench for the config bank
`timescale 1ns/1ps
module test_psu_cfg_regs;
   localparam logic [15:0] ID = 16'hC3A5; // Arbitrary value
   logic ref_clk = 0, resetn = 0, status_clear = 0, shedding_enable = 0, cmd_wr, cmd_rd;
   logic [15:0] per_phase_current_limit = 0, load_current = 0, vout_cmd_mv = 0, load_line_uohm = 0, iout_a = 0;
   logic [15:0] cmd_wdata, cmd_rdata, uv_trip_mv, d, dd;
   logic [13:0] input_lockout_mv;
   logic [7:0]  cmd_code, mfr_status;
   logic [2:0]  max_phase_m1;
   logic [1:0]  shed_phase_mode;
   logic        cmd_rvalid, cmd_unmapped, host_alert_output, input_undervoltage_lockout_sel_valid;
   logic [31:0] seed = 32'h20;
   logic [7:0]  cd [4] = '{8'hDF, 8'hE0, 8'hE4, 8'hE6};
   int fails = 0, total_checks = 0, e, mph = 3, al = 0, rv [4] = '{1, 1, 3, 3}, mk [4] = '{15, 3, 7, 7};
   int lk [4] = '{4500, 7250, 9000, 10300}, uv [8] = '{50, 100, 150, 200, 250, 300, 325, 400}, pc [5] = '{15, 20, 25, 30, 35};
   psu_cfg_regs #(.HW_PHASES_M1(3'h3), .PART_ID(ID)) dut_u (.*);
   psu_host_model h (.*);
   initial forever #10 ref_clk = ~ref_clk;
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic chk(input string n, input logic [15:0] x, input logic [15:0] g);
      total_checks++;
      if (g !== x) begin
         fails++;
         $display("unexpected %s: expected %h seen %h", n, x, g);
      end
   endtask
   task automatic summarize();
      if (fails == 0 && total_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      #200000;
      fails++;
      summarize();
   end
   initial begin
      repeat (12) @(posedge ref_clk);
      resetn <= 1'h1;
      for (int i = 0; i < 8; i++) begin
         h.rd(cd[i % 4], d);
         chk("register", rv[i % 4], d);
         dd = xs();
         if (i < 4) dd[2] = 1'h0;
         if (i < 4) rv[i] = dd & mk[i];
         if (i < 4) h.wr(cd[i], dd);
      end
      h.wr(8'hFC, 16'h0000);
      chk("id_write_flag", 0, cmd_unmapped);
      h.rd(8'hFC, d);
      chk("identity", ID, d);
      h.rd(8'h5C, d);
      chk("unmapped_flag", 1, cmd_unmapped);
      chk("unmapped_data", 0, d);
      chk("lock_valid", 1, input_undervoltage_lockout_sel_valid);
      for (int i = 0; i < 4; i++) begin
         h.wr(8'hE0, i);
         @(posedge ref_clk) #1;
         chk("lockout", lk[i], input_lockout_mv);
      end
      mph = rv[2];
      for (int i = 7; i >= 0; i--) begin
         h.wr(8'hE4, i);
         if (i <= 3) mph = i;
         else al = 3;
         h.rd(8'hE4, d);
         chk("phase", mph, d);
         chk("phase_out", mph, max_phase_m1);
         chk("alert", al, {mfr_status[3], host_alert_output});
      end
      @(posedge ref_clk) status_clear <= 1'h1;
      @(posedge ref_clk) status_clear <= 1'h0;
      #1 chk("alert", 0, {mfr_status[3], host_alert_output});
      for (int i = 0; i < 32; i++) begin
         d = xs();
         h.wr(8'hDF, d);
         @(posedge ref_clk);
         shedding_enable <= (i % 4) != 0;
         per_phase_current_limit <= 16'(40 + xs() % 120);
         load_current <= 16'(xs() % 160);
         repeat (3) @(posedge ref_clk);
         #1 e = d[2:0] < 4 ? pc[d[2:0]] : pc[4];
         e = !shedding_enable ? 3 : d[3] && load_current * 100 < per_phase_current_limit * 40 ? 0
             : load_current * 100 < per_phase_current_limit * 4 * e ? 1 : 3;
         chk("shed_mode", e, shed_phase_mode);
      end
      for (int i = 0; i < 8; i++) begin
         h.wr(8'hE6, i);
         @(posedge ref_clk);
         vout_cmd_mv <= 16'(300 + xs() % 1500);
         load_line_uohm <= 16'(xs() % 1000);
         iout_a <= 16'(xs() % 200);
         repeat (3) @(posedge ref_clk);
         #1 e = int'(vout_cmd_mv) - int'(load_line_uohm) * int'(iout_a) / 1000 - uv[i];
         chk("uv_trip", e < 0 ? 0 : e, uv_trip_mv);
      end
      summarize();
   end
endmodule
bind psu_cfg_regs psu_cfg_regs_checker #(.HW_PHASES_M1(HW_PHASES_M1), .PART_ID(PART_ID)) chk_u (.*);
